// ===== rtl/ppfs_map.vh
// register offsets, field positions, reset values and timing counts for the pin function block
`ifndef PPFS_MAP_VH
`define PPFS_MAP_VH

// register offsets (8-bit address space)
`define PPFS_ADDR_PORT_A_DIR 8'hEA
`define PPFS_ADDR_SERIAL_MODE 8'hED
`define PPFS_ADDR_TIMER_MODE 8'hEE
`define PPFS_ADDR_ANALOG_SEL 8'hEF
`define PPFS_ADDR_INT_PIN_MODE 8'hE0
`define PPFS_ADDR_SI_PIN_MODE 8'hE3

// port_a_direction fields
`define PPFS_DIR_MASK 8'h03

// serial_pin_mode fields
`define PPFS_SER_OUT_B_DRV 6
`define PPFS_SER_CS_SEL 5
`define PPFS_SER_OUT_A_DRV 3
`define PPFS_SER_MASK 8'h68

// timer_output_pin_mode fields
`define PPFS_TMR_SEL 7
`define PPFS_TMR_EN 6
`define PPFS_TMR_FIXED_RATE 5
`define PPFS_TMR_VAR_RATE 4
`define PPFS_TMR_MASK 8'hF0

// interrupt_pin_mode and serial_input_pin_mode fields
`define PPFS_INT_PIN_SEL 5
`define PPFS_INT_MASK 8'h20
`define PPFS_SI_SEL 2
`define PPFS_SI_MASK 8'h04

// reset values: used bits 0, unused bits 1
`define PPFS_RST_PORT_A_DIR 8'hFC
`define PPFS_RST_SERIAL_MODE 8'h97
`define PPFS_RST_TIMER_MODE 8'h0F
`define PPFS_RST_ANALOG_SEL 8'h00
`define PPFS_RST_INT_PIN_MODE 8'hDF
`define PPFS_RST_SI_PIN_MODE 8'hFB

// fixed-rate output division ratios of the system clock
`define PPFS_DIV_SLOW 2048
`define PPFS_DIV_FAST 1024
`define PPFS_HALF_SLOW 11'h3FF
`define PPFS_HALF_FAST 11'h1FF

`endif

// ===== rtl/ppfs_tone_gen.v
// timer output waveform generator: low, fixed-rate square wave or overflow toggle
`timescale 1ns/100ps
`default_nettype none
`include "ppfs_map.vh"

module ppfs_tone_gen (
  // clock and reset
  input wire sys_clk,
  input wire nrst,
  // mode controls
  input wire outEnable,
  input wire fixedRateSel,
  input wire varRateSel,
  // timer overflow pulse
  input wire timerOverflow,
  // waveform
  output reg toneOut_r
);

  // half-period counter; toggling each half period yields the full division
  reg [10:0] halfCnt_r;
  wire [10:0] halfLimit;

  // select half period; the rate bit is ignored in overflow mode
  assign halfLimit = fixedRateSel ? `PPFS_HALF_FAST : `PPFS_HALF_SLOW;

  // waveform state machine in one process
  always @(posedge sys_clk) begin
    if (!nrst) begin
      halfCnt_r <= 11'h000;
      toneOut_r <= 1'b0;
    end else if (!outEnable) begin
      // disabled: hold the line low and restart the divider
      halfCnt_r <= 11'h000;
      toneOut_r <= 1'b0;
    end else if (varRateSel) begin
      // divider held at zero so a return to fixed mode starts clean
      halfCnt_r <= 11'h000;
      if (timerOverflow) begin
        toneOut_r <= ~toneOut_r;
      end
    end else if (halfCnt_r >= halfLimit) begin
      // >= so a rate change mid-count never overshoots
      halfCnt_r <= 11'h000;
      toneOut_r <= ~toneOut_r;
    end else begin
      halfCnt_r <= halfCnt_r + 11'h001;
    end
  end

endmodule // ppfs_tone_gen
`default_nettype wire

// ===== rtl/ppfs_pin_func.v
// port pin function select: direction, drive mode and shared pin muxing
`timescale 1ns/100ps
`default_nettype none
`include "ppfs_map.vh"

// Overview of operation
// - port A direction bits: 0 input, 1 output
// - drive-select 1 makes serial output open drain
// - serial select 0 gives port pin always
// - interrupt select wins, else timer select chooses
// - timer output disabled drives constant low
// - fixed rate: clock over 2048 or 1024
// - variable rate toggles on each timer overflow
module ppfs_pin_func (
  // clock and reset
  input wire sys_clk,
  input wire nrst,
  // register port
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrEn,
  input wire regRdEn,
  output reg [7:0] regRdData_r,
  // port A pins
  input wire [1:0] portADataOut,
  input wire [1:0] portAPinIn,
  output wire [1:0] portAPinOut,
  output wire [1:0] portAPinOe,
  output wire [1:0] portAPinData,
  // serial output pins A and B
  input wire serOutAData,
  input wire serOutAEnable,
  input wire serOutBData,
  input wire serOutBEnable,
  output wire serOutAPinOut,
  output wire serOutAPinOe,
  output wire serOutBPinOut,
  output wire serOutBPinOe,
  // serial_port_pin: port / serial input / chip select
  input wire serialPortPinIn,
  input wire serialPortDataOut,
  input wire serialPortDirOut,
  input wire chipSelectLevel,
  output wire serialPortPinOut,
  output wire serialPortPinOe,
  output wire serialInData,
  output wire serialPortData,
  // shared_port_pin: port / external interrupt / timer output
  input wire sharedPortPinIn,
  input wire sharedPortDataOut,
  input wire sharedPortDirOut,
  input wire timerOverflow,
  output wire sharedPortPinOut,
  output wire sharedPortPinOe,
  output wire externalInterruptIn,
  output wire sharedPortData,
  // analog capable pins
  output wire [7:0] analogInputEnable,
  // decoded mode indications
  output wire serialInputActive,
  output wire chipSelectActive,
  output wire timerOutputActive,
  output wire interruptPinActive
);

  ////////////////////////////////////////////////////////////////////////////
  // register storage

  reg [7:0] portADir_r; // port_a_direction
  reg [7:0] serialMode_r; // serial_pin_mode
  reg [7:0] timerMode_r; // timer_output_pin_mode
  reg [7:0] analogSel_r; // analog_input_select
  reg [7:0] intPinMode_r; // interrupt_pin_mode (select bit only)
  reg [7:0] siPinMode_r; // serial_input_pin_mode (select bit only)
  reg [7:0] rdMux_nxt; // read data next value

  // merge a write with the fixed-one pattern of unused bits
  function [7:0] maskedWrite;
    input [7:0] data;
    input [7:0] usedMask;
    begin
      maskedWrite = (data & usedMask) | ~usedMask;
    end
  endfunction

  // one-hot address hit test shared by all registers
  function addrHit;
    input [7:0] addr;
    input [7:0] target;
    begin
      addrHit = (addr == target);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register writes

  // all registers load on a write strobe that hits their offset
  always @(posedge sys_clk) begin
    if (!nrst) begin
      portADir_r <= `PPFS_RST_PORT_A_DIR;
      serialMode_r <= `PPFS_RST_SERIAL_MODE;
      timerMode_r <= `PPFS_RST_TIMER_MODE;
      analogSel_r <= `PPFS_RST_ANALOG_SEL;
      intPinMode_r <= `PPFS_RST_INT_PIN_MODE;
      siPinMode_r <= `PPFS_RST_SI_PIN_MODE;
    end else if (regWrEn) begin
      if (addrHit(regAddr, `PPFS_ADDR_PORT_A_DIR)) begin
        portADir_r <= maskedWrite(regWrData, `PPFS_DIR_MASK);
      end
      if (addrHit(regAddr, `PPFS_ADDR_SERIAL_MODE)) begin
        serialMode_r <= maskedWrite(regWrData, `PPFS_SER_MASK);
      end
      if (addrHit(regAddr, `PPFS_ADDR_TIMER_MODE)) begin
        timerMode_r <= maskedWrite(regWrData, `PPFS_TMR_MASK);
      end
      if (addrHit(regAddr, `PPFS_ADDR_ANALOG_SEL)) begin
        analogSel_r <= regWrData;
      end
      if (addrHit(regAddr, `PPFS_ADDR_INT_PIN_MODE)) begin
        intPinMode_r <= maskedWrite(regWrData, `PPFS_INT_MASK);
      end
      if (addrHit(regAddr, `PPFS_ADDR_SI_PIN_MODE)) begin
        siPinMode_r <= maskedWrite(regWrData, `PPFS_SI_MASK);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register reads

  // write-only registers read all ones, as would a floating bus;
  // an unmapped address also reads all ones
  always @* begin
    rdMux_nxt = 8'hFF;
    if (addrHit(regAddr, `PPFS_ADDR_SERIAL_MODE)) begin
      rdMux_nxt = serialMode_r;
    end else if (addrHit(regAddr, `PPFS_ADDR_TIMER_MODE)) begin
      rdMux_nxt = timerMode_r;
    end else if (addrHit(regAddr, `PPFS_ADDR_INT_PIN_MODE)) begin
      rdMux_nxt = intPinMode_r;
    end else if (addrHit(regAddr, `PPFS_ADDR_SI_PIN_MODE)) begin
      rdMux_nxt = siPinMode_r;
    end
  end

  // read data valid the cycle after the strobe; zero otherwise
  always @(posedge sys_clk) begin
    if (!nrst) begin
      regRdData_r <= 8'h00;
    end else if (regRdEn) begin
      regRdData_r <= rdMux_nxt;
    end else begin
      regRdData_r <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // port A direction

  // pin drives only while its direction bit is set
  assign portAPinOe = portADir_r[1:0];
  assign portAPinOut = portADataOut;
  assign portAPinData = portAPinIn;

  ////////////////////////////////////////////////////////////////////////////
  // serial output drive mode

  wire serAOpenDrain = serialMode_r[`PPFS_SER_OUT_A_DRV];
  wire serBOpenDrain = serialMode_r[`PPFS_SER_OUT_B_DRV];

  // open drain: high-side off, so only a low level is driven
  assign serOutAPinOut = serAOpenDrain ? 1'b0 : serOutAData;
  assign serOutAPinOe = serOutAEnable & (~serAOpenDrain | ~serOutAData);
  assign serOutBPinOut = serBOpenDrain ? 1'b0 : serOutBData;
  assign serOutBPinOe = serOutBEnable & (~serBOpenDrain | ~serOutBData);

  ////////////////////////////////////////////////////////////////////////////
  // serial input / chip select shared pin

  wire siSelect = siPinMode_r[`PPFS_SI_SEL];
  wire csSelect = serialMode_r[`PPFS_SER_CS_SEL];

  // chip select is ignored unless the serial function is selected
  assign serialInputActive = siSelect & ~csSelect;
  assign chipSelectActive = siSelect & csSelect;
  assign serialPortPinOut = chipSelectActive ? chipSelectLevel : serialPortDataOut;
  assign serialPortPinOe = chipSelectActive | (~siSelect & serialPortDirOut);
  assign serialInData = serialInputActive ? serialPortPinIn : 1'b1;
  assign serialPortData = serialPortPinIn;

  ////////////////////////////////////////////////////////////////////////////
  // port / interrupt / timer output shared pin

  wire toneLevel;

  // interrupt select overrides timer output select
  assign interruptPinActive = intPinMode_r[`PPFS_INT_PIN_SEL];
  assign timerOutputActive = ~interruptPinActive & timerMode_r[`PPFS_TMR_SEL];

  // waveform generator for the timer output function
  ppfs_tone_gen toneGen (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .outEnable(timerOutputActive & timerMode_r[`PPFS_TMR_EN]),
    .fixedRateSel(timerMode_r[`PPFS_TMR_FIXED_RATE]),
    .varRateSel(timerMode_r[`PPFS_TMR_VAR_RATE]),
    .timerOverflow(timerOverflow),
    .toneOut_r(toneLevel)
  );

  // interrupt mode never drives; timer mode always drives
  assign sharedPortPinOut = timerOutputActive ? toneLevel : sharedPortDataOut;
  assign sharedPortPinOe = timerOutputActive |
    (~interruptPinActive & sharedPortDirOut);
  assign externalInterruptIn = interruptPinActive ? sharedPortPinIn : 1'b0;
  assign sharedPortData = sharedPortPinIn;

  ////////////////////////////////////////////////////////////////////////////
  // analog input select

  // a set bit hands the pin to the converter
  assign analogInputEnable = analogSel_r;

endmodule // ppfs_pin_func
`default_nettype wire

// ===== testbench/ppfs_checker.sv
// port-level assertions for the pin function block
`timescale 1ns/100ps
`default_nettype none
module ppfs_checker (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // register read side
  input wire logic regRdEn,
  input wire logic [7:0] regRdData_r,
  // pin and peripheral signals
  input wire logic [1:0] portADataOut,
  input wire logic [1:0] portAPinOut,
  input wire logic serOutAEnable,
  input wire logic serOutAPinOe,
  input wire logic serOutBData,
  input wire logic serOutBPinOut,
  input wire logic serOutBPinOe,
  input wire logic chipSelectLevel,
  input wire logic serialPortPinOut,
  input wire logic serialPortPinOe,
  input wire logic serialInData,
  input wire logic sharedPortPinIn,
  input wire logic sharedPortPinOe,
  input wire logic externalInterruptIn,
  // decoded modes
  input wire logic serialInputActive,
  input wire logic chipSelectActive,
  input wire logic timerOutputActive,
  input wire logic interruptPinActive
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // read data only stands in the cycle after a strobe
  a_rd_idle: assert property (!$past(regRdEn) |-> regRdData_r == 8'h00)
    else $error("read data outside its cycle");
  a_porta_out: assert property (portAPinOut == portADataOut)
    else $error("port A data not passed");
  a_sera_oe: assert property (serOutAPinOe |-> serOutAEnable)
    else $error("serial A driven without request");
  a_serb_high: assert property (serOutBPinOe && serOutBPinOut |-> serOutBData)
    else $error("serial B drives wrong level");
  a_si_cs_excl: assert property (!(serialInputActive && chipSelectActive))
    else $error("serial input and chip select both active");
  a_cs_drive: assert property (chipSelectActive |->
    serialPortPinOe && serialPortPinOut == chipSelectLevel)
    else $error("chip select not driven");
  a_si_idle: assert property (!serialInputActive |-> serialInData)
    else $error("serial input not idle high");
  a_int_wins: assert property (interruptPinActive |->
    !timerOutputActive && externalInterruptIn == sharedPortPinIn)
    else $error("interrupt select not winning");
  a_int_off: assert property (!interruptPinActive |-> !externalInterruptIn)
    else $error("interrupt input leaks");
  a_tmr_oe: assert property (timerOutputActive |-> sharedPortPinOe)
    else $error("timer output not driven");
endmodule // ppfs_checker
`default_nettype wire

// ===== testbench/ppfs_pins_model.sv
// model of the timer overflow source and shared pin level
`timescale 1ns/100ps
`default_nettype none
module ppfs_pins_model #(parameter int OVF_GAP = 40) (
  // clock and run request
  input wire logic sys_clk,
  input wire logic ovfRun,
  // peripheral side outputs
  output logic timerOverflow = 1'b0,
  output logic sharedPinLevel = 1'b0
);
  int gapCnt = 0; // cycles since the last overflow
  // one-cycle overflow pulse every OVF_GAP cycles; pin level changes every cycle so
  // that a stale or settled-unknown value never passes as a match
  always @(posedge sys_clk) begin
    gapCnt <= (ovfRun && gapCnt < OVF_GAP - 1) ? gapCnt + 1 : 0;
    timerOverflow <= ovfRun && gapCnt == OVF_GAP - 1;
    sharedPinLevel <= ~sharedPinLevel;
  end
endmodule // ppfs_pins_model
`default_nettype wire

// ===== testbench/tb_top.sv
// self-checking bench for the pin function block
`timescale 1ns/100ps
`default_nettype none
`include "ppfs_map.vh"
module tb_top;
  logic sys_clk = 1'b0; // 200 MHz system clock
  logic nrst = 1'b0; // sync reset, active low
  logic [7:0] regAddr = 8'h00; // register address
  logic [7:0] regWrData = 8'h00; // write data
  logic regWrEn = 1'b0; // write strobe
  logic regRdEn = 1'b0; // read strobe
  logic ovfRun = 1'b0; // lets the model pulse overflows
  logic [13:0] pins = 14'h0000; // pin levels and core requests
  wire [7:0] regRdData_r, analogInputEnable;
  wire [1:0] portAPinOe;
  wire serOutAPinOut, serOutAPinOe, sharedPortPinOut, timerOverflow, sharedPortPinIn;
  wire serialInputActive, chipSelectActive, timerOutputActive, interruptPinActive;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0; // timeout counter
  logic [23:0] rows [11] = '{24'hEEFFFF, 24'hEE000F, 24'hEDFFFF, 24'hED0097, 24'hE0FFFF,
    24'hE000DF, 24'hE3FFFF, 24'hE300FB, 24'hEA03FF, 24'hEFA5FF, 24'h5512FF};
  ppfs_pin_func dut (.sys_clk, .nrst, .regAddr, .regWrData, .regWrEn, .regRdEn,
    .regRdData_r, .portADataOut(pins[1:0]), .portAPinIn(pins[3:2]), .portAPinOut(),
    .portAPinOe, .portAPinData(), .serOutAData(pins[4]), .serOutAEnable(pins[5]),
    .serOutBData(pins[6]), .serOutBEnable(pins[7]), .serOutAPinOut, .serOutAPinOe,
    .serOutBPinOut(), .serOutBPinOe(), .serialPortPinIn(pins[8]),
    .serialPortDataOut(pins[9]), .serialPortDirOut(pins[10]), .chipSelectLevel(pins[11]),
    .serialPortPinOut(), .serialPortPinOe(), .serialInData(), .serialPortData(),
    .sharedPortPinIn, .sharedPortDataOut(pins[12]), .sharedPortDirOut(pins[13]),
    .timerOverflow, .sharedPortPinOut, .sharedPortPinOe(), .externalInterruptIn(),
    .sharedPortData(), .analogInputEnable, .serialInputActive, .chipSelectActive,
    .timerOutputActive, .interruptPinActive);
  ppfs_pins_model #(.OVF_GAP(40)) model (.sys_clk, .ovfRun, .timerOverflow,
    .sharedPinLevel(sharedPortPinIn));
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  // cut a hang short
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge sys_clk);
    regWrEn <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge sys_clk);
    regRdEn <= 1'b0;
    #1 chk({8'h00, regRdData_r}, {8'h00, exp});
    @(posedge sys_clk);
  endtask
  // cycles between two tone edges, after lining up on a first edge
  task automatic gap(input logic [15:0] exp);
    logic [15:0] n;
    logic last;
    repeat (2) begin
      // the sample that finds an edge is one cycle after it, so count it as one
      n = 16'd1;
      @(negedge sys_clk);
      last = sharedPortPinOut;
      while (sharedPortPinOut === last && n < 16'd3000) begin
        @(negedge sys_clk);
        n++;
      end
    end
    chk(n, exp);
    @(posedge sys_clk);
  endtask
  initial begin
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    pins <= 14'h1000;
    @(posedge sys_clk);
    rd(`PPFS_ADDR_TIMER_MODE, `PPFS_RST_TIMER_MODE);
    rd(`PPFS_ADDR_SERIAL_MODE, `PPFS_RST_SERIAL_MODE);
    #1 chk({14'h0000, portAPinOe}, 16'h0000);
    @(posedge sys_clk);
    // write each row, read it back
    foreach (rows[i]) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16], rows[i][7:0]);
    end
    #1 chk({14'h0000, portAPinOe}, 16'h0003);
    chk({8'h00, analogInputEnable}, 16'h00A5);
    @(posedge sys_clk);
    wr(8'hE3, 8'h04);
    wr(8'hED, 8'h20);
    #1 chk({serialInputActive, chipSelectActive}, 16'h0001);
    @(posedge sys_clk);
    wr(8'hE3, 8'h00);
    #1 chk({serialInputActive, chipSelectActive}, 16'h0000);
    @(posedge sys_clk);
    wr(8'hE3, 8'h04);
    wr(8'hED, 8'h48);
    pins <= 14'h1020;
    @(posedge sys_clk);
    #1 chk({serialInputActive, serOutAPinOut, serOutAPinOe}, 16'h0005);
    @(posedge sys_clk);
    pins <= 14'h1030;
    @(posedge sys_clk);
    #1 chk({serOutAPinOut, serOutAPinOe}, 16'h0000);
    @(posedge sys_clk);
    wr(8'hED, 8'h00);
    #1 chk({serOutAPinOut, serOutAPinOe}, 16'h0003);
    @(posedge sys_clk);
    wr(8'hEE, 8'h80);
    repeat (20) @(posedge sys_clk);
    #1 chk({timerOutputActive, sharedPortPinOut}, 16'h0002);
    @(posedge sys_clk);
    wr(8'hEE, 8'hC0);
    gap(16'(`PPFS_DIV_SLOW / 2));
    wr(8'hEE, 8'hE0);
    gap(16'(`PPFS_DIV_FAST / 2));
    ovfRun <= 1'b1;
    wr(8'hEE, 8'hF0);
    gap(16'd40);
    wr(8'hE0, 8'h20);
    #1 chk({interruptPinActive, timerOutputActive}, 16'h0002);
    tally_and_finish();
  end
endmodule // tb_top
bind ppfs_pin_func ppfs_checker chk_i (.sys_clk, .nrst, .regRdEn, .regRdData_r,
  .portADataOut, .portAPinOut, .serOutAEnable, .serOutAPinOe, .serOutBData,
  .serOutBPinOut, .serOutBPinOe, .chipSelectLevel, .serialPortPinOut, .serialPortPinOe,
  .serialInData, .sharedPortPinIn, .sharedPortPinOe, .externalInterruptIn,
  .serialInputActive, .chipSelectActive, .timerOutputActive, .interruptPinActive);
`default_nettype wire
